// ===== design/block_sync_pkg.sv
// constants and types for the reset, run and block-sync controller
// assumes a single 25 MHz clock that also serves as the master clock
package block_sync_pkg;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_ID_REV = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_BLOCK_COUNT = 8'h03;

  // control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_VALID_BIT = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'h03;

  // status fields
  localparam int STAT_RUNNING_BIT = 0;
  localparam int STAT_DIR_OUT_BIT = 1;
  localparam int STAT_PENDING_BIT = 2;
  localparam int STAT_STRAP_VALID_BIT = 3;

  // identity, values arbitrary
  localparam logic [3:0] DEVICE_ID = 4'h5;
  localparam logic [3:0] REVISION_ID = 4'h1;

  // line timing: clocks per half-bit cell, cells per sub-frame, sub-frames per block
  localparam logic [1:0] UI_CYCLES_M1 = 2'h3;
  localparam logic [5:0] UI_PER_SUBFRAME_M1 = 6'h3F;
  localparam logic [8:0] SUBFRAMES_PER_BLOCK_M1 = 9'h17F;
  localparam logic [5:0] PREAMBLE_UI = 6'h08;
  localparam logic [4:0] VALIDITY_SLOT = 5'h1C;
  localparam logic [4:0] PARITY_SLOT = 5'h1F;

  // input sync must be seen high this many master clocks
  localparam logic [1:0] SYNC_MIN_CYCLES = 2'h3;

  // preambles, written for a preceding low level
  localparam logic [7:0] PREAMBLE_BLOCK = 8'hE8;
  localparam logic [7:0] PREAMBLE_FIRST = 8'hE2;
  localparam logic [7:0] PREAMBLE_SECOND = 8'hE4;

  typedef enum logic {
    low_power,
    running
  } run_state_t;

endpackage

// ===== design/bmc_encoder.sv
// biphase-mark line encoder with preamble insertion
// assumes ui_tick marks the first clock of each half-bit cell
`timescale 1ns/100ps
`default_nettype none
module bmc_encoder
  import block_sync_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic active,
  input wire logic ui_tick,
  input wire logic [5:0] ui_index,
  input wire logic [7:0] preamble,
  input wire logic data_bit,
  output logic level
);

  logic inv;
  logic next_level;
  logic next_inv;

  always_comb begin
    next_level = level;
    next_inv = inv;
    if (!active) begin
      next_level = 1'b0;
      next_inv = 1'b0;
    end else if (ui_tick) begin
      if (ui_index < PREAMBLE_UI) begin
        // preamble polarity follows the level left by the last sub-frame
        if (ui_index == 6'h00) begin
          next_inv = level;
          next_level = preamble[7] ^ level;
        end else begin
          next_level = preamble[~ui_index[2:0]] ^ inv;
        end
      end else if (!ui_index[0]) begin
        next_level = ~level;
      end else if (data_bit) begin
        next_level = ~level;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b0;
      inv <= 1'b0;
    end else begin
      level <= next_level;
      inv <= next_inv;
    end
  end

endmodule
`default_nettype wire

// ===== design/reset_run_and_block_sync.sv
// reset, run control, identity and block-start sync for the transmitter
// assumes register strobes and the sync input are synchronous to clk
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module reset_run_and_block_sync
  import block_sync_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic block_sync_direction_strap,
  input wire logic block_start_sync_in,
  output logic block_start_sync_out,
  output logic block_start_sync_oe_b,
  output logic line_out_pos,
  output logic line_out_neg
);

  // strap capture
  logic strap_valid;
  logic dir_out;
  logic next_strap_valid;
  logic next_dir_out;

  // run control
  run_state_t state;
  run_state_t next_state;
  logic [7:0] control;
  logic [7:0] next_control;

  // timing counters
  logic [1:0] ui_div;
  logic [5:0] ui_index;
  logic [8:0] subframe;
  // wraps silently; software works with differences
  logic [7:0] block_count;
  logic [1:0] next_ui_div;
  logic [5:0] next_ui_index;
  logic [8:0] next_subframe;
  logic [7:0] next_block_count;

  // sync input qualification
  logic [1:0] high_count;
  logic armed;
  logic pending;
  logic [1:0] next_high_count;
  logic next_armed;
  logic next_pending;

  // registered outputs
  logic [DATA_W-1:0] next_rdata;
  logic next_sync_out;
  logic next_sync_oe_b;
  logic next_pos;
  logic next_neg;

  logic is_running;
  logic ui_tick;
  logic subframe_end;
  logic sync_seen;
  logic [7:0] preamble;
  logic data_bit;
  logic enc_level;

  assign is_running = (state == running);
  // one tick at the start of each four-clock half-bit cell
  assign ui_tick = is_running && (ui_div == 2'h0);
  assign subframe_end = is_running && (ui_div == UI_CYCLES_M1)
                        && (ui_index == UI_PER_SUBFRAME_M1);

  // strap is caught by a clocked process after release, never by the reset
  // a strap moved later is ignored until the next reset
  always_comb begin
    next_strap_valid = 1'b1;
    next_dir_out = dir_out;
    if (!strap_valid) begin
      next_dir_out = block_sync_direction_strap;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_valid <= 1'b0;
      dir_out <= 1'b0;
    end else begin
      strap_valid <= next_strap_valid;
      dir_out <= next_dir_out;
    end
  end

  // control register and run state
  always_comb begin
    next_control = control;
    next_state = state;
    if (reg_write && (reg_addr == ADDR_CONTROL)) begin
      next_control = reg_wdata & CONTROL_MASK;
    end
    // a write of 0 to run drops back to low power at once
    // run bit starts operation
    if (next_control[CTRL_RUN_BIT]) begin
      next_state = running;
    end else begin
      next_state = low_power;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control <= CONTROL_RESET;
      state <= low_power;
    end else begin
      control <= next_control;
      state <= next_state;
    end
  end

  // input sync qualification: one request per high pulse
  // the line must fall before another request can be armed
  assign sync_seen = is_running && strap_valid && !dir_out && armed
                     && block_start_sync_in
                     && (high_count == SYNC_MIN_CYCLES - 2'h1);

  always_comb begin
    next_high_count = high_count;
    next_armed = armed;
    next_pending = pending;
    if (!block_start_sync_in) begin
      next_high_count = 2'h0;
      next_armed = 1'b1;
    end else if (high_count != SYNC_MIN_CYCLES) begin
      next_high_count = high_count + 2'h1;
    end
    // consuming the request at a boundary; a new one in that cycle wins
    if (subframe_end || !is_running) begin
      next_pending = 1'b0;
    end
    if (sync_seen) begin
      next_pending = 1'b1;
      next_armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_count <= 2'h0;
      armed <= 1'b0;
      pending <= 1'b0;
    end else begin
      high_count <= next_high_count;
      armed <= next_armed;
      pending <= next_pending;
    end
  end

  // sub-frame and block timing; cell and sub-frame counters held at zero in low power, block count kept
  always_comb begin
    next_ui_div = ui_div;
    next_ui_index = ui_index;
    next_subframe = subframe;
    next_block_count = block_count;
    if (!is_running) begin
      next_ui_div = 2'h0;
      next_ui_index = 6'h00;
      next_subframe = 9'h000;
    end else if (ui_div == UI_CYCLES_M1) begin
      next_ui_div = 2'h0;
      if (ui_index == UI_PER_SUBFRAME_M1) begin
        next_ui_index = 6'h00;
        if (pending || sync_seen) begin
          next_subframe = 9'h000;
          next_block_count = block_count + 8'h01;
        end else if (subframe == SUBFRAMES_PER_BLOCK_M1) begin
          next_subframe = 9'h000;
          next_block_count = block_count + 8'h01;
        end else begin
          next_subframe = subframe + 9'h001;
        end
      end else begin
        next_ui_index = ui_index + 6'h01;
      end
    end else begin
      next_ui_div = ui_div + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ui_div <= 2'h0;
      ui_index <= 6'h00;
      subframe <= 9'h000;
      block_count <= 8'h00;
    end else begin
      ui_div <= next_ui_div;
      ui_index <= next_ui_index;
      subframe <= next_subframe;
      block_count <= next_block_count;
    end
  end

  // payload is silence; validity flag set by software, parity keeps it even
  always_comb begin
    preamble = PREAMBLE_FIRST;
    if (subframe == 9'h000) begin
      preamble = PREAMBLE_BLOCK;
    end else if (subframe[0]) begin
      preamble = PREAMBLE_SECOND;
    end
    data_bit = 1'b0;
    if ((ui_index[5:1] == VALIDITY_SLOT) || (ui_index[5:1] == PARITY_SLOT)) begin
      data_bit = control[CTRL_VALID_BIT];
    end
  end

  bmc_encoder encoder (
    .clk(clk),
    .rst_b(rst_b),
    .active(is_running),
    .ui_tick(ui_tick),
    .ui_index(ui_index),
    .preamble(preamble),
    .data_bit(data_bit),
    .level(enc_level)
  );

  // register read port: data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_ID_REV: begin
          next_rdata = {DEVICE_ID, REVISION_ID};
        end
        ADDR_CONTROL: begin
          next_rdata = control;
        end
        ADDR_STATUS: begin
          next_rdata[STAT_RUNNING_BIT] = is_running;
          next_rdata[STAT_DIR_OUT_BIT] = dir_out;
          next_rdata[STAT_PENDING_BIT] = pending;
          next_rdata[STAT_STRAP_VALID_BIT] = strap_valid;
        end
        ADDR_BLOCK_COUNT: begin
          next_rdata = block_count;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // pin outputs
  // the sync pin leads the line pins by the two-clock encoder lag
  always_comb begin
    next_sync_out = dir_out && strap_valid && (next_state == running)
                    && (next_subframe == 9'h000);
    next_sync_oe_b = !(dir_out && strap_valid);
    next_pos = is_running && enc_level;
    next_neg = is_running && !enc_level;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
      block_start_sync_out <= 1'b0;
      block_start_sync_oe_b <= 1'b1;
      line_out_pos <= 1'b0;
      line_out_neg <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      block_start_sync_out <= next_sync_out;
      block_start_sync_oe_b <= next_sync_oe_b;
      line_out_pos <= next_pos;
      line_out_neg <= next_neg;
    end
  end

endmodule
`default_nettype wire

// ===== dv/block_sync_props.sv
// assertions on the ports of the reset, run and block-sync controller
// bound to the top; one clock domain, reset asynchronous
`timescale 1ns/100ps
`default_nettype none
module block_sync_props
  import block_sync_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic block_sync_direction_strap,
  input wire logic block_start_sync_in,
  input wire logic block_start_sync_out,
  input wire logic block_start_sync_oe_b,
  input wire logic line_out_pos,
  input wire logic line_out_neg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic run_wr;
  logic run_seen;
  logic next_run_seen;
  logic [8:0] hi_cnt;
  logic [8:0] next_hi_cnt;
  assign run_wr = reg_write && reg_addr == ADDR_CONTROL;
  always_comb begin
    next_run_seen = run_seen | (run_wr & reg_wdata[CTRL_RUN_BIT]);
    next_hi_cnt = block_start_sync_out ? hi_cnt + 9'h001 : 9'h000;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_seen <= 1'b0;
      hi_cnt <= 9'h000;
    end else begin
      run_seen <= next_run_seen;
      hi_cnt <= next_hi_cnt;
    end
  end
  a_reset_idle_out: assert property ($rose(rst_b) |-> !line_out_pos && !line_out_neg
    && block_start_sync_oe_b && reg_rdata == 8'h00) else $error("outputs active out of reset");
  a_idle_until_run: assert property (!run_seen |-> !line_out_pos && !line_out_neg)
    else $error("line driven before run");
  a_run_starts_line: assert property (run_wr && reg_wdata[CTRL_RUN_BIT]
    |-> ##[1:3] (line_out_pos != line_out_neg)) else $error("run did not start line");
  a_stop_lines_low: assert property (run_wr && !reg_wdata[CTRL_RUN_BIT]
    |-> ##2 (!line_out_pos && !line_out_neg) [*4]) else $error("line active after stop");
  a_id_read: assert property (reg_read && reg_addr == ADDR_ID_REV
    |=> reg_rdata == {DEVICE_ID, REVISION_ID}) else $error("identity read wrong");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data without read");
  // strap high drives; strap caught one edge after release, enable one later
  a_oe_out_mode: assert property ($rose(rst_b) && block_sync_direction_strap
    |-> ##2 !block_start_sync_oe_b) else $error("sync line not driven");
  a_oe_in_mode: assert property ($rose(rst_b) && !block_sync_direction_strap
    |=> block_start_sync_oe_b [*8]) else $error("sync line driven in input mode");
  a_pulse_len: assert property ($fell(block_start_sync_out) && !block_start_sync_oe_b
    |-> hi_cnt == 9'h100) else $error("sync pulse length wrong");
  c_run_start: cover property (run_wr && reg_wdata[CTRL_RUN_BIT]);
  c_pulse_done: cover property ($fell(block_start_sync_out));
  c_sync_in_held: cover property (block_start_sync_oe_b && block_start_sync_in [*3]);
endmodule
bind reset_run_and_block_sync block_sync_props u_props (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .block_sync_direction_strap(block_sync_direction_strap),
  .block_start_sync_in(block_start_sync_in), .block_start_sync_out(block_start_sync_out),
  .block_start_sync_oe_b(block_start_sync_oe_b), .line_out_pos(line_out_pos),
  .line_out_neg(line_out_neg)
);
`default_nettype wire

// ===== dv/sync_source.sv
// external logic driving the shared block-start sync line
// shares clock and reset with the device under test
`timescale 1ns/100ps
`default_nettype none
module sync_source (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [3:0] len,
  output logic sync_level
);
  logic [3:0] left;
  logic [3:0] next_left;
  always_comb begin
    next_left = go ? len : (left != 4'h0 ? left - 4'h1 : 4'h0);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 4'h0;
    end else begin
      left <= next_left;
    end
  end
  // idles low, never released
  assign sync_level = left != 4'h0;
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the reset, run and block-sync controller
// drives the register port and an external sync source at 25 MHz
`timescale 1ns/100ps
`default_nettype none
module tb
  import block_sync_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic strap = 1'b1;
  logic go = 1'b0;
  logic [3:0] plen = 4'h3;
  logic [7:0] reg_rdata;
  logic [7:0] blk;
  logic sync_out, sync_oe_b, pos, neg, ext_sync, sync_line;
  int fail_count = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  assign sync_line = sync_oe_b ? ext_sync : sync_out;
  reset_run_and_block_sync u_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .block_sync_direction_strap(strap), .block_start_sync_in(sync_line),
    .block_start_sync_out(sync_out), .block_start_sync_oe_b(sync_oe_b),
    .line_out_pos(pos), .line_out_neg(neg)
  );
  // one reset for device and sync source
  sync_source u_src (.clk(clk), .rst_b(rst_b), .go(go), .len(plen), .sync_level(ext_sync));
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // X as expected value only captures
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    if (exp !== 8'hXX) check8(reg_rdata, exp);
    blk = reg_rdata;
  endtask
  task automatic pulse(input logic [3:0] n);
    @(posedge clk);
    plen <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (600) @(posedge clk);
  endtask
  task automatic do_reset(input logic s);
    rst_b <= 1'b0;
    strap <= s;
    repeat (11) @(posedge clk);
    @(negedge clk);
    check8({5'h00, pos, neg, sync_oe_b}, 8'h01);
    check8(reg_rdata, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    rd(ADDR_ID_REV, {DEVICE_ID, REVISION_ID});
    check8({6'h00, pos, neg}, 8'h00);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_STATUS, 8'h0A);
    check8({7'h00, sync_oe_b}, 8'h00);
    rd(8'h10, 8'h00);
    wr(ADDR_ID_REV, 8'hFF);
    rd(ADDR_ID_REV, {DEVICE_ID, REVISION_ID});
    wr(ADDR_CONTROL, 8'h02);
    rd(ADDR_CONTROL, 8'h02);
    wr(ADDR_CONTROL, 8'hFF);
    rd(ADDR_CONTROL, CONTROL_MASK);
    rd(ADDR_STATUS, 8'h0B);
    check8({7'h00, pos ^ neg}, 8'h01);
    check8({7'h00, sync_out}, 8'h01);
    repeat (300) @(posedge clk);
    @(negedge clk);
    check8({7'h00, sync_out}, 8'h00);
    @(posedge clk);
    do_reset(1'b0);
    rd(ADDR_STATUS, 8'h08);
    check8({7'h00, sync_oe_b}, 8'h01);
    wr(ADDR_CONTROL, 8'h01);
    rd(ADDR_BLOCK_COUNT, 8'h00);
    // two clocks high is too short to realign
    pulse(4'h2);
    rd(ADDR_BLOCK_COUNT, blk);
    pulse(4'h3);
    rd(ADDR_BLOCK_COUNT, blk + 8'h01);
    rd(ADDR_STATUS, 8'h09);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_STATUS, 8'h08);
    check8({6'h00, pos, neg}, 8'h00);
    wr(ADDR_CONTROL, 8'h01);
    repeat (50) @(posedge clk);
    do_reset(1'b1);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_STATUS, 8'h0A);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run;
  end
endmodule
`default_nettype wire
